// >>> include/orient_pkg.sv
// Shared constants and types of the orientation detection engine.
package orient_pkg;
  // ==========================================================================
  // Widths and scales
  // ==========================================================================
  localparam int ACC_W        = 16; // Width of one signed axis sample.
  localparam int TILT_SCALE_LOG2 = 5; // Tilt limits use 32 counts per g.
  localparam int FINE_LOG2    = 8; // Internal compare scale, 256 counts per g.
  localparam int SQ_W         = 26; // Width of squared magnitudes.
  // Full-scale square at 32 counts per g (32 * 32).
  localparam logic [10:0] ONE_G_SQ_32 = 11'h400;

  // ==========================================================================
  // Reset values of the settings
  // ==========================================================================
  // A sine of 16/32 selects the 30 degree threshold angle.
  localparam logic [4:0] HYST_RST     = 5'h10;
  localparam logic [7:0] TILT_LL_RST  = 8'h0c;
  localparam logic [7:0] TILT_UL_RST  = 8'hff;
  localparam logic [7:0] QUAL_RST     = 8'h00;
  localparam logic [1:0] TILT_ODR_RST = 2'h0;

  // ==========================================================================
  // Reported orientation states
  // ==========================================================================
  typedef enum logic [2:0] {
    face_up,
    face_down,
    rot_0,
    rot_90,
    rot_180,
    rot_270
  } orient_e;
endpackage

// >>> include/pacer_if.sv
// Carrier between the sample pacer and the classification engine.
interface pacer_if;
  logic       tick; // One pulse per tilt-position sample period.
  logic [1:0] odr;  // Selected tilt-position output data rate.
  modport pacer  (input odr, output tick);
  modport engine (output odr, input tick);
endinterface

// >>> hdl/tilt_sample_pacer.sv
// Decimator that turns the sample strobe into tilt-position sample ticks.
module tilt_sample_pacer #(
  parameter logic [7:0] DIV0 = 8'h08, // Strobes per tick for rate code 0.
  parameter logic [7:0] DIV1 = 8'h04, // Strobes per tick for rate code 1.
  parameter logic [7:0] DIV2 = 8'h02, // Strobes per tick for rate code 2.
  parameter logic [7:0] DIV3 = 8'h01  // Strobes per tick for rate code 3.
) (
  input  wire logic ref_clk_i,
  input  wire logic nrst_i,
  input  wire logic acc_valid_i,
  pacer_if.pacer    pif
);
  // ==========================================================================
  // Divider state
  // ==========================================================================
  logic [7:0] cnt_ff;      // Strobes seen in the current period.
  logic [7:0] nxt_cnt;
  logic       tick_ff;     // Registered tick, one cycle wide.
  logic       nxt_tick;
  logic [7:0] div_sel;     // Divisor chosen by the rate field.

  // Pick the divisor; a zero divisor behaves like one strobe per tick.
  always_comb begin
    case (pif.odr)
      2'h0:    div_sel = DIV0;
      2'h1:    div_sel = DIV1;
      2'h2:    div_sel = DIV2;
      default: div_sel = DIV3;
    endcase
  end

  // Count strobes and fire a tick on the last one of each period.
  // A rate change takes hold at the next strobe, as the count is compared with the new divisor at once.
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_tick = 1'b0;
    if (acc_valid_i) begin
      if (cnt_ff + 8'h01 >= div_sel) begin
        nxt_cnt  = 8'h00;
        nxt_tick = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 8'h01;
      end
    end
  end

  // Register the divider.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_ff  <= 8'h00;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign pif.tick = tick_ff;

  // Ticks never come without a strobe in the cycle before.
  a_tick_cause: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    tick_ff |-> $past(acc_valid_i))
    else $error("Tick without a sample strobe.");
endmodule

// >>> hdl/orientation_detect_engine.sv
// Orientation classification, hysteresis and qualification engine.
module orientation_detect_engine #(
  parameter int          ONE_G_LOG2 = 12,    // Sample counts per g, log2.
  parameter logic [7:0]  DIV0       = 8'h08, // Strobes per tick, rate 0.
  parameter logic [7:0]  DIV1       = 8'h04, // Strobes per tick, rate 1.
  parameter logic [7:0]  DIV2       = 8'h02, // Strobes per tick, rate 2.
  parameter logic [7:0]  DIV3       = 8'h01  // Strobes per tick, rate 3.
) (
  input  wire logic                           ref_clk_i,
  input  wire logic                           nrst_i,
  input  wire logic                           acc_valid_i,
  input  wire logic signed [orient_pkg::ACC_W-1:0] acc_x_i,
  input  wire logic signed [orient_pkg::ACC_W-1:0] acc_y_i,
  input  wire logic signed [orient_pkg::ACC_W-1:0] acc_z_i,
  input  wire logic [4:0]                     hysteresis_setting_i,
  input  wire logic [7:0]                     tilt_angle_lower_limit_i,
  input  wire logic [7:0]                     tilt_angle_upper_limit_i,
  input  wire logic [7:0]                     qual_count_i,
  input  wire logic [1:0]                     control_register_three_odr_i,
  output logic [2:0]                          orientation_o,
  output logic [2:0]                          prev_orientation_o,
  output logic                                orientation_change_o
);
  localparam int SH = ONE_G_LOG2 - orient_pkg::FINE_LOG2;
  localparam int W  = orient_pkg::SQ_W;

  // ==========================================================================
  // Sample pacing
  // ==========================================================================
  pacer_if pif ();

  assign pif.odr = control_register_three_odr_i;

  tilt_sample_pacer #(
    .DIV0 (DIV0),
    .DIV1 (DIV1),
    .DIV2 (DIV2),
    .DIV3 (DIV3)
  ) u_pacer (
    .ref_clk_i   (ref_clk_i),
    .nrst_i      (nrst_i),
    .acc_valid_i (acc_valid_i),
    .pif         (pif.pacer)
  );

  // ==========================================================================
  // Helper functions
  // ==========================================================================
  // Magnitude of a sample at 256 counts per g.
  function automatic logic [W-1:0] fine_mag(
    input logic signed [orient_pkg::ACC_W-1:0] v);
    logic signed [orient_pkg::ACC_W-1:0] s;
    s = v >>> SH;
    fine_mag = s[orient_pkg::ACC_W-1] ? W'(-s) : W'(s);
  endfunction

  // Minor axis strictly inside plus and minus sin(phi).
  function automatic logic minor_ok(input logic [W-1:0] m,
                                    input logic [4:0]   s);
    minor_ok = m < (W'(s) << 3);
  endfunction

  // Major axis above cos(phi), done in squares to avoid a root.
  function automatic logic major_ok(input logic [W-1:0] m,
                                    input logic [4:0]   s);
    logic [W-1:0] lim;
    lim = (W'(orient_pkg::ONE_G_SQ_32) - W'(s) * W'(s)) << 6;
    major_ok = (m * m) > lim;
  endfunction

  // ==========================================================================
  // Sample capture
  // ==========================================================================
  // The latest set is held so a tick evaluates one coherent sample set.
  logic signed [orient_pkg::ACC_W-1:0] ax_ff, ay_ff, az_ff;
  logic signed [orient_pkg::ACC_W-1:0] nxt_ax, nxt_ay, nxt_az;

  // Take a new set on every strobe, otherwise hold.
  always_comb begin
    nxt_ax = acc_valid_i ? acc_x_i : ax_ff;
    nxt_ay = acc_valid_i ? acc_y_i : ay_ff;
    nxt_az = acc_valid_i ? acc_z_i : az_ff;
  end

  // Register the sample set.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ax_ff <= '0;
      ay_ff <= '0;
      az_ff <= '0;
    end else begin
      ax_ff <= nxt_ax;
      ay_ff <= nxt_ay;
      az_ff <= nxt_az;
    end
  end

  // ==========================================================================
  // Classification
  // ==========================================================================
  logic [W-1:0]        mx, my, xy_sq, ll_sq, ul_sq;
  logic                tilt_ok;   // Device tilted enough to read rotation.
  orient_pkg::orient_e cand;      // Candidate state from this sample set.
  orient_pkg::orient_e report_ff; // Reported state.

  // Tilt limits are sin(theta) at 32 counts per g, scaled by 8 here.
  always_comb begin
    mx      = fine_mag(ax_ff);
    my      = fine_mag(ay_ff);
    xy_sq   = mx * mx + my * my;
    ll_sq   = (W'(tilt_angle_lower_limit_i) << 3) *
              (W'(tilt_angle_lower_limit_i) << 3);
    ul_sq   = (W'(tilt_angle_upper_limit_i) << 3) *
              (W'(tilt_angle_upper_limit_i) << 3);
    tilt_ok = (xy_sq > ll_sq) && (xy_sq <= ul_sq);
  end

  // Pick the candidate. Inside the hysteresis band nothing matches and the
  // reported state is kept, which stops flipping near 45 degrees.
  always_comb begin
    cand = report_ff;
    if (!tilt_ok) begin
      cand = az_ff[orient_pkg::ACC_W-1] ? orient_pkg::face_down
                                        : orient_pkg::face_up;
    end else if (major_ok(my, hysteresis_setting_i) &&
                 minor_ok(mx, hysteresis_setting_i)) begin
      cand = ay_ff[orient_pkg::ACC_W-1] ? orient_pkg::rot_180
                                        : orient_pkg::rot_0;
    end else if (major_ok(mx, hysteresis_setting_i) &&
                 minor_ok(my, hysteresis_setting_i)) begin
      cand = ax_ff[orient_pkg::ACC_W-1] ? orient_pkg::rot_270
                                        : orient_pkg::rot_90;
    end
  end

  // ==========================================================================
  // Qualification and report
  // ==========================================================================
  orient_pkg::orient_e pend_ff, nxt_pend, nxt_report, prev_ff, nxt_prev;
  logic [7:0]          cnt_ff, nxt_cnt;
  logic                chg_ff, nxt_chg;
  logic [8:0]          cnt_inc;

  // A candidate must be seen on qual_count_i consecutive ticks; the host
  // derives that count as delay seconds times the tick rate.
  always_comb begin
    nxt_pend   = pend_ff;
    nxt_report = report_ff;
    nxt_prev   = prev_ff;
    nxt_cnt    = cnt_ff;
    nxt_chg    = 1'b0;
    cnt_inc    = {1'b0, cnt_ff} + 9'h001;
    if (pif.tick) begin
      if (cand == report_ff) begin
        nxt_pend = report_ff;
        nxt_cnt  = 8'h00;
      end else if (cand != pend_ff) begin
        nxt_pend = cand;
        nxt_cnt  = 8'h01;
        if (qual_count_i <= 8'h01) begin
          nxt_report = cand;
          nxt_prev   = report_ff;
          nxt_chg    = 1'b1;
          nxt_cnt    = 8'h00;
        end
      end else if (cnt_inc >= {1'b0, qual_count_i}) begin
        nxt_report = cand;
        nxt_prev   = report_ff;
        nxt_chg    = 1'b1;
        nxt_cnt    = 8'h00;
      end else begin
        nxt_cnt = cnt_inc[7:0];
      end
    end
  end

  // Register the qualification state.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      report_ff <= orient_pkg::face_up;
      pend_ff   <= orient_pkg::face_up;
      prev_ff   <= orient_pkg::face_up;
      cnt_ff    <= 8'h00;
      chg_ff    <= 1'b0;
    end else begin
      report_ff <= nxt_report;
      pend_ff   <= nxt_pend;
      prev_ff   <= nxt_prev;
      cnt_ff    <= nxt_cnt;
      chg_ff    <= nxt_chg;
    end
  end

  assign orientation_o        = report_ff;
  assign prev_orientation_o   = prev_ff;
  assign orientation_change_o = chg_ff;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  a_change_pulse: assert property (
    chg_ff |-> report_ff != $past(report_ff) && prev_ff == $past(report_ff))
    else $error("Change pulse without a new state.");
  a_update_on_tick: assert property (
    report_ff != $past(report_ff) |-> $past(pif.tick) && chg_ff)
    else $error("State moved outside a sample tick.");
  a_flat_face: assert property (
    chg_ff && (report_ff == orient_pkg::face_up ||
               report_ff == orient_pkg::face_down) |-> !$past(tilt_ok))
    else $error("Face state taken while tilted.");
  a_rot_tilted: assert property (
    chg_ff && report_ff >= orient_pkg::rot_0 |-> $past(tilt_ok))
    else $error("Rotation changed below the tilt limit.");
  a_rot0_axes: assert property (
    chg_ff && report_ff == orient_pkg::rot_0 |->
      $past(ay_ff) > 0 && $past(my) > $past(mx))
    else $error("Upright state without a positive Y major axis.");
  a_rot90_band: assert property (
    chg_ff && report_ff == orient_pkg::rot_90 |->
      $past(my) < (W'($past(hysteresis_setting_i)) << 3))
    else $error("Sideways state with Y outside the band.");
  a_qual_full: assert property (
    chg_ff && $past(qual_count_i) > 8'h01 |->
      {1'b0, $past(cnt_ff)} + 9'h001 >= {1'b0, $past(qual_count_i)})
    else $error("Change accepted before the count was reached.");
  a_restart: assert property (
    pif.tick && cand != report_ff && cand != pend_ff &&
    qual_count_i > 8'h01 |=> cnt_ff == 8'h01 && !chg_ff)
    else $error("New candidate did not restart the count.");

  c_to_rot90: cover property (chg_ff && report_ff == orient_pkg::rot_90);
  c_to_face_dn: cover property (chg_ff && report_ff == orient_pkg::face_down);
  c_restart: cover property (pif.tick && cand != pend_ff && cnt_ff > 8'h01);
endmodule

// >>> sim/orient_sample_source.sv
// Model of the acceleration sample path that feeds the engine.
module orient_sample_source (
  input  wire logic                               ref_clk_i,
  output logic                                    acc_valid_o,
  output logic signed [orient_pkg::ACC_W-1:0]     acc_x_o,
  output logic signed [orient_pkg::ACC_W-1:0]     acc_y_o,
  output logic signed [orient_pkg::ACC_W-1:0]     acc_z_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==================================================
  // Sample strobe driver
  // ==================================================
  // Lines start quiet so the engine sees defined values from time zero.
  initial begin
    acc_valid_o = 1'b0;
    acc_x_o = '0;
    acc_y_o = '0;
    acc_z_o = '0;
  end

  // Sends n back-to-back sets, changing lines only at falling edges.
  // Idle lines show the inverse, so a stale set never passes for new.
  task automatic put(input logic signed [orient_pkg::ACC_W-1:0] x, y, z,
                     input int n);
    @(negedge ref_clk_i);
    acc_valid_o = 1'b1;
    acc_x_o = x;
    acc_y_o = y;
    acc_z_o = z;
    repeat (n) @(negedge ref_clk_i);
    acc_valid_o = 1'b0;
    acc_x_o = ~x;
    acc_y_o = ~y;
    acc_z_o = ~z;
  endtask
endmodule

// >>> sim/orientation_detect_engine_tb.sv
// Self-checking bench of the orientation detection engine.
module orientation_detect_engine_tb;
  timeunit 1ns;
  timeprecision 1ns;

  // ==================================================
  // Signals
  // ==================================================
  localparam int W = orient_pkg::ACC_W;
  localparam logic signed [W-1:0] G = 16'sh1000; // One g, 4096 counts.
  localparam logic signed [W-1:0] O = 16'sh0000; // Zero g.
  logic           ref_clk = 1'b0; // 100 ns clock.
  logic           nrst;           // Active-low reset.
  logic [4:0]     hyst;           // Hysteresis setting.
  logic [7:0]     ll;             // Tilt lower limit.
  logic [7:0]     ul;             // Tilt upper limit.
  logic [7:0]     qual;           // Qualification count.
  logic [1:0]     odr;            // Tilt rate code.
  logic           valid;          // Sample strobe from the model.
  logic signed [W-1:0] sx, sy, sz; // Samples from the model.
  logic [2:0]     orient;         // Reported orientation.
  logic [2:0]     prev_o;         // Orientation before last change.
  logic           chg;            // Change pulse.
  logic [2:0]     last, he, te;   // Expected states.
  logic signed [W-1:0] hx, tx;    // Held and target X samples.
  int             mismatches = 0;
  int             n_tests = 0;
  int             changes = 0;    // Change pulses seen.
  int             base, k;
  int             dv[4] = '{8, 4, 2, 1}; // Strobes per tick per code.
  logic signed [W-1:0] rx[4] = '{O, G, O, -G};
  logic signed [W-1:0] ry[4] = '{G, O, -G, O};
  logic [2:0]     re[4] = '{orient_pkg::rot_0, orient_pkg::rot_90,
                            orient_pkg::rot_180, orient_pkg::rot_270};

  // ==================================================
  // Clock, design and model
  // ==================================================
  always #50 ref_clk = ~ref_clk;

  // Sampled mid-cycle, where the pulse has settled; a pulse wider than
  // one cycle would be counted twice here.
  always @(negedge ref_clk) begin
    if (chg === 1'b1) changes++;
  end

  orient_sample_source orient_sample_source_i (.ref_clk_i(ref_clk),
    .acc_valid_o(valid), .acc_x_o(sx), .acc_y_o(sy), .acc_z_o(sz));

  orientation_detect_engine #(.ONE_G_LOG2(12), .DIV0(8'h08),
    .DIV1(8'h04), .DIV2(8'h02), .DIV3(8'h01)
  ) orientation_detect_engine_i (
    .ref_clk_i(ref_clk), .nrst_i(nrst), .acc_valid_i(valid),
    .acc_x_i(sx), .acc_y_i(sy), .acc_z_i(sz),
    .hysteresis_setting_i(hyst), .tilt_angle_lower_limit_i(ll),
    .tilt_angle_upper_limit_i(ul), .qual_count_i(qual),
    .control_register_three_odr_i(odr), .orientation_o(orient),
    .prev_orientation_o(prev_o), .orientation_change_o(chg));

  // ==================================================
  // Helpers
  // ==================================================
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Sends n sets, lets the two-cycle answer land, then compares.
  task automatic step(input logic signed [W-1:0] x, y, z, input int n,
                      input logic [2:0] exp);
    orient_sample_source_i.put(x, y, z, n);
    repeat (4) @(negedge ref_clk);
    check({13'h0000, orient}, {13'h0000, exp});
  endtask

  task automatic end_of_test;
    if (mismatches == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==================================================
  // Tests
  // ==================================================
  initial begin
    nrst = 1'b0;
    hyst = orient_pkg::HYST_RST;
    ll = orient_pkg::TILT_LL_RST;
    ul = orient_pkg::TILT_UL_RST;
    qual = orient_pkg::QUAL_RST;
    odr = 2'h3;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    nrst = 1'b1;
    check(16'(orient), 16'(orient_pkg::face_up));
    step(O, O, -G, 1, orient_pkg::face_down);
    step(O, O, G, 1, orient_pkg::face_up);
    last = orient_pkg::face_up;
    for (k = 0; k < 4; k++) begin
      step(rx[k], ry[k], O, 1, re[k]);
      check(16'(prev_o), 16'(last));
      last = re[k];
    end
    step(O, G, O, 1, orient_pkg::rot_0);
    // A tilt of 45 degrees must not flip; 62 degrees must.
    step(16'sh0b50, 16'sh0b50, O, 1, orient_pkg::rot_0);
    step(16'sh0e21, 16'sh0783, O, 1, orient_pkg::rot_90);
    step(16'sh0b50, 16'sh0b50, O, 1, orient_pkg::rot_90);
    step(16'sh0783, 16'sh0e21, O, 1, orient_pkg::rot_0);
    // At 50 degrees only the narrower band lets the state move.
    step(16'sh0c42, 16'sh0a49, O, 1, orient_pkg::rot_0);
    hyst = 5'h16;
    step(16'sh0c42, 16'sh0a49, O, 1, orient_pkg::rot_90);
    hyst = orient_pkg::HYST_RST;
    step(O, G, O, 1, orient_pkg::rot_0);
    // The XY magnitude is 28.8 counts: above 28, below 30.
    ll = 8'h1e;
    step(O, 16'sh0e66, 16'sh06fa, 1, orient_pkg::face_up);
    ll = 8'h1c;
    step(O, 16'sh0e66, 16'sh06fa, 1, orient_pkg::rot_0);
    ll = orient_pkg::TILT_LL_RST;
    // A tilt above the upper limit falls back to the face states.
    ul = 8'h1c;
    step(O, G, -G, 1, orient_pkg::face_down);
    ul = orient_pkg::TILT_UL_RST;
    step(O, G, O, 1, orient_pkg::rot_0);
    // Three sets is a 0.3 s delay at a 10 Hz tilt rate.
    qual = 8'h03;
    base = changes;
    step(G, O, O, 2, orient_pkg::rot_0);
    step(O, G, O, 1, orient_pkg::rot_0);
    step(G, O, O, 2, orient_pkg::rot_0);
    step(G, O, O, 1, orient_pkg::rot_90);
    step(O, -G, O, 2, orient_pkg::rot_90);
    step(O, G, O, 1, orient_pkg::rot_90);
    step(O, -G, O, 2, orient_pkg::rot_90);
    step(O, -G, O, 1, orient_pkg::rot_180);
    check(16'(changes - base), 16'h0002);
    // One divisor's worth of strobes gives exactly one tick.
    qual = 8'h02;
    hx = O;
    he = orient_pkg::rot_180;
    for (k = 0; k < 4; k++) begin
      odr = k[1:0];
      tx = k[0] ? -G : G;
      te = k[0] ? orient_pkg::rot_270 : orient_pkg::rot_90;
      step(hx, hx == O ? -G : O, O, 16, he);
      step(tx, O, O, dv[k], he);
      step(tx, O, O, dv[k], te);
      hx = tx;
      he = te;
    end
    // A reset in mid-run must bring back the idle report.
    nrst = 1'b0;
    @(negedge ref_clk);
    check(16'(orient), 16'(orient_pkg::face_up));
    check(16'(prev_o), 16'(orient_pkg::face_up));
    nrst = 1'b1;
    step(O, O, -G, 2, orient_pkg::face_down);
    end_of_test;
  end

  // ==================================================
  // Watchdog
  // ==================================================
  // The tests need well under 1000 cycles; 5000 marks a hang.
  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    end_of_test;
  end
endmodule
